// file: hw/sensor_cmd_pkg.sv
// Constants and carrier types of the sensor command interpreter
package sensor_cmd_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned US_HZ = 1_000_000;
  localparam int unsigned CYC_PER_US = (CLK_HZ + US_HZ - 1) / US_HZ;
  localparam logic [4:0] US_DIV_LAST = 5'(CYC_PER_US - 1);
  // ************************************************************
  // Characters and keywords
  // ************************************************************
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [71:0] KW_SETDEV = "setdevice";
  localparam logic [71:0] KW_RREG = {40'h0, "rreg"};
  localparam logic [71:0] KW_WREG = {40'h0, "wreg"};
  localparam logic [71:0] KW_COLLECT = {16'h0, "collect"};
  localparam logic [71:0] KW_STOP = {40'h0, "stop"};
  localparam logic [3:0] KW_MAX_LEN = 4'h9;
  localparam logic [2:0] MAX_ARGS = 3'h4;
  // ************************************************************
  // Records and targets
  // ************************************************************
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [3:0] HDR_BYTES = 4'h4;
  localparam logic [2:0] RES_TOP = 3'h6;
  localparam logic [2:0] MAX_TGT = 3'h4;
  localparam logic [3:0] DEFAULT_CS = 4'h1;
  localparam logic [31:0] CS_MAX = 32'h4;
  localparam logic [31:0] ADDR_LIMIT = 32'h100;
  localparam logic [31:0] MASK_LIMIT = 32'h80;
  localparam logic [31:0] NIB_LIMIT = 32'h10;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_SETDEV = 3'h1,
    K_RREG = 3'h2,
    K_WREG = 3'h3,
    K_COLLECT = 3'h4,
    K_STOP = 3'h5
  } cmd_kind_t;
  typedef struct packed {
    logic write;
    logic is_spi;
    logic [3:0] target;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic [39:0] rdata;
    logic [2:0] nbytes;
  } bus_rsp_t;
  typedef struct packed {
    cmd_kind_t kind;
    logic has_reg;
    logic [7:0] addr;
    logic [39:0] value;
    logic collecting;
  } reply_t;
endpackage

// file: hw/sensor_cmd_interp.sv
// Command interpreter: text command parser, sensor access sequencer, bulk record streamer
`timescale 1ns/10ps
`default_nettype none
module sensor_cmd_interp #(
  parameter logic [6:0][7:0] RESULT_ADDR = {8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00}
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial command bytes
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  // Reply descriptors
  output logic reply_valid,
  output sensor_cmd_pkg::reply_t reply,
  input wire logic reply_ready,
  // Bulk record bytes
  output logic bulk_valid,
  output logic [7:0] bulk_data,
  input wire logic bulk_ready,
  // Sensor bus engine
  output logic probe_req,
  input wire logic probe_done,
  input wire logic [15:0] i2c_present,
  input wire logic [3:0] spi_present,
  output logic bus_valid,
  output sensor_cmd_pkg::bus_req_t bus_req,
  input wire logic bus_done,
  input wire sensor_cmd_pkg::bus_rsp_t bus_rsp,
  // Status
  output logic bus_is_spi,
  output logic [3:0] target_sel,
  output logic collecting
);
  import sensor_cmd_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    S_PROBE = 3'h0,
    S_IDLE = 3'h1,
    S_CMD_BUS = 3'h2,
    S_REPLY = 3'h3,
    S_SCAN = 3'h4,
    S_SMP_BUS = 3'h5,
    S_EMIT = 3'h6
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic rdy;
    logic [71:0] kw;
    logic [3:0] kwlen;
    logic argph;
    logic hexm;
    logic inarg;
    logic [2:0] argn;
    logic bad;
    logic [3:0] ndig;
    logic xseen;
    logic [3:0][31:0] val;
    logic pend;
    cmd_kind_t kind;
    logic spi;
    logic [3:0] tgt;
    logic [31:0] ival;
    logic [6:0] mask;
    logic [15:0] list;
    logic [2:0] cnt;
    logic coll;
    logic [4:0] div;
    logic tick;
    logic [31:0] uscnt;
    logic due;
    logic inset;
    logic [2:0] board;
    logic [2:0] cur;
    logic prb;
    logic bv;
    bus_req_t breq;
    logic [39:0] rdata;
    logic [2:0] nb;
    logic [7:0] raddr;
    logic [2:0] rboard;
    logic [3:0] eidx;
    logic rv;
    reply_t rep;
    logic hv;
    logic [7:0] hd;
    logic tv;
    logic [7:0] td;
  } st_t;

  st_t q;
  st_t n;
  logic push;
  logic [7:0] pbyte;
  logic [7:0] ch;
  logic [4:0] hx;
  logic [3:0] cd;
  logic [31:0] cv;
  logic [1:0] ai;
  logic [2:0] sh;
  logic list_ok;
  cmd_kind_t k;

  // ************************************************************
  // Decoding helpers
  // ************************************************************
  function automatic cmd_kind_t kw_kind(input logic [71:0] w);
    if (w == KW_SETDEV) return K_SETDEV;
    else if (w == KW_RREG) return K_RREG;
    else if (w == KW_WREG) return K_WREG;
    else if (w == KW_COLLECT) return K_COLLECT;
    else if (w == KW_STOP) return K_STOP;
    else return K_NONE;
  endfunction

  function automatic logic [2:0] args_of(input cmd_kind_t kd);
    unique case (kd)
      K_SETDEV: return 3'h1;
      K_RREG: return 3'h1;
      K_WREG: return 3'h2;
      K_COLLECT: return 3'h4;
      K_STOP: return 3'h0;
      default: return 3'h7;
    endcase
  endfunction

  function automatic logic [4:0] hex_digit(input logic [7:0] c);
    if (c >= "0" && c <= "9") return {1'b1, c[3:0]};
    else if ((c >= "a" && c <= "f") || (c >= "A" && c <= "F")) return {1'b1, 4'(c[3:0] + 4'h9)};
    else return 5'h00;
  endfunction

  function automatic logic [3:0] lowest(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (m[i]) r = 4'(i);
    end
    return r;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    n = q;
    push = 1'b0;
    pbyte = 8'h00;
    ch = cmd_byte;
    hx = hex_digit(cmd_byte);
    ai = q.argn[1:0];
    cd = q.inarg ? q.ndig : 4'h0;
    cv = q.inarg ? q.val[ai] : 32'h0;
    sh = 3'h0;
    k = kw_kind(q.kw);
    n.tick = 1'b0;
    // Microsecond enable and sample timer
    if (q.div == US_DIV_LAST)
    begin
      n.div = 5'h00;
      n.tick = 1'b1;
    end
    else
      n.div = q.div + 5'h01;
    if (q.tick && q.coll)
    begin
      if (q.ival == 32'h0 || q.uscnt >= q.ival - 32'h1)
      begin
        n.uscnt = 32'h0;
        n.due = 1'b1;
      end
      else
        n.uscnt = q.uscnt + 32'h1;
    end
    // Bulk buffer drain
    if (q.hv && bulk_ready)
    begin
      n.hv = q.tv;
      n.hd = q.td;
      n.tv = 1'b0;
    end
    // Line parser
    if (cmd_valid && q.rdy)
    begin
      if ((ch == CH_SP || ch == CH_LF) && q.inarg)
      begin
        n.inarg = 1'b0;
        if (q.ndig == 4'h0) n.bad = 1'b1;
        n.argn = q.argn + 3'h1;
      end
      if (ch == CH_SP && !q.argph)
      begin
        n.argph = 1'b1;
        n.hexm = (k == K_RREG) || (k == K_WREG);
      end
      else if (ch == CH_LF)
      begin
        if (k != K_NONE && !n.bad && n.argn == args_of(k))
        begin
          n.pend = 1'b1;
          n.kind = k;
        end
        n.kw = 72'h0;
        n.kwlen = 4'h0;
        n.argph = 1'b0;
        n.inarg = 1'b0;
        n.argn = 3'h0;
        n.bad = 1'b0;
      end
      else if (ch != CH_CR && ch != CH_SP)
      begin
        if (!q.argph)
        begin
          n.kw = {q.kw[63:0], ch};
          if (q.kwlen == KW_MAX_LEN) n.bad = 1'b1;
          else n.kwlen = q.kwlen + 4'h1;
        end
        else
        begin
          if (!q.inarg)
          begin
            if (q.argn == MAX_ARGS) n.bad = 1'b1;
            n.inarg = 1'b1;
            n.xseen = 1'b0;
          end
          n.ndig = (cd == 4'hf) ? cd : cd + 4'h1;
          if (q.hexm)
          begin
            if (ch == CH_X && cd == 4'h1 && cv == 32'h0 && !(q.inarg && q.xseen))
            begin
              n.xseen = 1'b1;
              n.ndig = 4'h0;
            end
            else if (hx[4]) n.val[ai] = {cv[27:0], hx[3:0]};
            else n.bad = 1'b1;
          end
          else if (ch >= CH_0 && ch <= CH_9) n.val[ai] = cv * 32'd10 + {28'h0, ch[3:0]};
          else n.bad = 1'b1;
        end
      end
    end
    // Collect arguments check
    list_ok = q.val[3] >= 32'h1 && q.val[3] <= {29'h0, MAX_TGT} && q.val[1] < MASK_LIMIT;
    if (q.val[2][31:16] != 16'h0) list_ok = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (q.spi && 32'(i) < q.val[3] && (q.val[2][4*i +: 4] == 4'h0 || q.val[2][4*i +: 4] > 4'h4))
        list_ok = 1'b0;
    end
    // Sequencer
    unique case (q.fsm)
      S_PROBE:
      begin
        n.prb = 1'b1;
        if (probe_done)
        begin
          n.prb = 1'b0;
          n.fsm = S_IDLE;
          if (|i2c_present)
          begin
            n.spi = 1'b0;
            n.tgt = lowest(i2c_present);
          end
          else
          begin
            n.spi = 1'b1;
            n.tgt = (|spi_present) ? lowest({12'h0, spi_present}) + 4'h1 : DEFAULT_CS;
          end
        end
      end
      S_IDLE:
      begin
        if (q.pend)
        begin
          n.pend = 1'b0;
          n.rep.kind = q.kind;
          n.rep.has_reg = 1'b0;
          unique case (q.kind)
            K_SETDEV:
            begin
              if (q.spi ? (q.val[0] >= 32'h1 && q.val[0] <= CS_MAX) : q.val[0] < NIB_LIMIT)
              begin
                n.tgt = q.val[0][3:0];
                n.fsm = S_REPLY;
              end
            end
            K_RREG, K_WREG:
            begin
              if (q.val[0] < ADDR_LIMIT)
              begin
                n.pend = 1'b1;
                n.bv = 1'b1;
                n.breq = '{q.kind == K_WREG, q.spi, q.tgt, q.val[0][7:0], q.val[1]};
                n.fsm = S_CMD_BUS;
              end
            end
            K_COLLECT:
            begin
              if (list_ok)
              begin
                n.ival = q.val[0];
                n.mask = q.val[1][6:0];
                n.list = q.val[2][15:0];
                n.cnt = q.val[3][2:0];
                n.coll = 1'b1;
                n.due = 1'b1;
                n.uscnt = 32'h0;
                n.inset = 1'b0;
                n.fsm = S_REPLY;
              end
            end
            K_STOP:
            begin
              n.coll = 1'b0;
              n.inset = 1'b0;
              n.due = 1'b0;
              n.fsm = S_REPLY;
            end
            default: n.pend = 1'b0;
          endcase
          if (n.fsm == S_REPLY)
          begin
            n.pend = 1'b1;
            n.rv = 1'b1;
            n.rep.collecting = n.coll;
          end
        end
        else if (q.inset)
          n.fsm = S_SCAN;
        else if (q.coll && q.due)
        begin
          n.inset = 1'b1;
          n.due = 1'b0;
          n.board = 3'h0;
          n.cur = RES_TOP;
          n.fsm = S_SCAN;
        end
      end
      S_CMD_BUS:
      begin
        if (bus_done)
        begin
          n.bv = 1'b0;
          n.rv = 1'b1;
          n.rep.has_reg = (q.kind == K_RREG);
          n.rep.addr = q.breq.addr;
          n.rep.value = bus_rsp.rdata;
          n.rep.collecting = q.coll;
          n.fsm = S_REPLY;
        end
      end
      S_REPLY:
      begin
        if (reply_ready)
        begin
          n.rv = 1'b0;
          n.pend = 1'b0;
          n.fsm = S_IDLE;
        end
      end
      S_SCAN:
      begin
        if (q.board >= q.cnt)
        begin
          n.inset = 1'b0;
          n.fsm = S_IDLE;
        end
        else
        begin
          if (q.mask[q.cur])
          begin
            n.bv = 1'b1;
            n.breq = '{1'b0, q.spi, q.list[{q.board[1:0], 2'b00} +: 4], RESULT_ADDR[q.cur], 32'h0};
            n.rboard = q.board;
            n.fsm = S_SMP_BUS;
          end
          if (q.cur == 3'h0)
          begin
            n.cur = RES_TOP;
            n.board = q.board + 3'h1;
          end
          else
            n.cur = q.cur - 3'h1;
        end
      end
      S_SMP_BUS:
      begin
        if (bus_done)
        begin
          n.bv = 1'b0;
          n.rdata = bus_rsp.rdata;
          n.nb = bus_rsp.nbytes;
          n.raddr = q.breq.addr;
          n.eidx = 4'h0;
          n.fsm = S_EMIT;
        end
      end
      S_EMIT:
      begin
        if (!q.tv)
        begin
          push = 1'b1;
          unique case (q.eidx)
            4'h0: pbyte = SYNC_BYTE;
            4'h1: pbyte = {5'h00, q.rboard} + 8'h01;
            4'h2: pbyte = q.raddr;
            4'h3: pbyte = {5'h00, q.nb};
            default:
            begin
              sh = q.nb - 3'h1 - 3'(q.eidx - HDR_BYTES);
              pbyte = q.rdata[{sh, 3'b000} +: 8];
            end
          endcase
          if (q.eidx == {1'b0, q.nb} + HDR_BYTES - 4'h1) n.fsm = S_IDLE;
          else n.eidx = q.eidx + 4'h1;
        end
      end
      default: n.fsm = S_IDLE;
    endcase
    // Bulk buffer fill
    if (push)
    begin
      if (!n.hv)
      begin
        n.hv = 1'b1;
        n.hd = pbyte;
      end
      else
      begin
        n.tv = 1'b1;
        n.td = pbyte;
      end
    end
    n.rdy = !n.pend;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) q <= '0;
    else q <= n;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign cmd_ready = q.rdy;
  assign reply_valid = q.rv;
  assign reply = q.rep;
  assign bulk_valid = q.hv;
  assign bulk_data = q.hd;
  assign probe_req = q.prb;
  assign bus_valid = q.bv;
  assign bus_req = q.breq;
  assign bus_is_spi = q.spi;
  assign target_sel = q.tgt;
  assign collecting = q.coll;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_sync_byte_zero: assert property (push && q.eidx == 4'h0 |-> pbyte == 8'h00 && q.fsm == S_EMIT)
    else $error("record does not open with zero");
  a_board_index_pos: assert property (push && q.eidx == 4'h1 |-> pbyte == {5'h00, q.rboard} + 8'h01 && q.rboard < q.cnt)
    else $error("board index wrong");
  a_record_start: assert property (q.fsm == S_SMP_BUS && bus_done |=> q.fsm == S_EMIT && q.eidx == 4'h0 && q.nb == $past(bus_rsp.nbytes))
    else $error("record not started after read");
  a_bus_req_hold: assert property (q.bv && !bus_done |=> q.bv && $stable(q.breq))
    else $error("bus request dropped or changed");
  a_count_range: assert property (q.coll |-> q.cnt >= 3'h1 && q.cnt <= 3'h4)
    else $error("target count out of range");
  a_collect_reply_state: assert property (q.rv && q.rep.kind == K_COLLECT |-> q.rep.collecting && q.coll)
    else $error("collect reply without collecting state");
  a_stop_reply_idle: assert property ($rose(q.rv) && q.rep.kind == K_STOP |-> !q.rep.collecting ##1 !q.coll)
    else $error("stop reply not idle");
  a_spi_fallback: assert property (q.fsm == S_PROBE && probe_done && i2c_present == 16'h0 |=> q.spi && q.fsm == S_IDLE)
    else $error("no SPI fallback");
  a_cmd_stall: assert property (q.pend |-> !cmd_ready)
    else $error("command taken while one pending");
  a_tick_period: assert property (q.tick |-> ##20 q.tick)
    else $error("microsecond enable period wrong");
  a_bulk_hold: assert property (q.hv && !bulk_ready |=> q.hv && $stable(q.hd))
    else $error("bulk byte lost under stall");
  a_board_order: assert property (q.fsm == S_SCAN && q.cur == 3'h0 && q.board < q.cnt |=> q.board == $past(q.board) + 3'h1 && q.cur == 3'h6)
    else $error("board advanced out of order");
  a_rreg_reply: assert property (q.fsm == S_CMD_BUS && bus_done && q.kind == K_RREG |=> q.rv && q.rep.has_reg && q.rep.value == $past(bus_rsp.rdata))
    else $error("read reply wrong");

  c_collect_ack: cover property (q.rv && q.rep.kind == K_COLLECT);
  c_second_board: cover property (push && q.eidx == 4'h1 && q.rboard == 3'h1);
  c_read_reply: cover property (q.rv && q.rep.has_reg);
  c_bulk_full: cover property (q.hv && q.tv && !bulk_ready);
endmodule
`default_nettype wire

// file: test/sensor_bus_model.sv
// Behavioural sensor bus engine that answers probes and register accesses
`timescale 1ns/10ps
`default_nettype none
module sensor_bus_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bench set-up
  input wire logic [15:0] i2c_fit,
  input wire logic [3:0] spi_fit,
  input wire logic [3:0] lat,
  // Interpreter side
  input wire logic probe_req,
  output logic probe_done,
  output logic [15:0] i2c_present,
  output logic [3:0] spi_present,
  input wire logic bus_valid,
  input wire sensor_cmd_pkg::bus_req_t bus_req,
  output logic bus_done,
  output sensor_cmd_pkg::bus_rsp_t bus_rsp
);
  import sensor_cmd_pkg::*;
  logic [3:0] wait_q;
  logic [42:0] junk_q;
  logic [2:0] nb;
  logic [39:0] val;
  // Result width of 2 to 4 bytes follows the register address
  assign nb = 3'(2 + bus_req.addr % 3);
  assign val = 40'({4'h0, bus_req.target, bus_req.addr, 16'h5ac3}) & ((40'h1 << (8 * nb)) - 40'h1);
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_q <= 4'h0;
      junk_q <= 43'h2aa_5555_aaaa;
      probe_done <= 1'b0;
      bus_done <= 1'b0;
      i2c_present <= 16'h0000;
      spi_present <= 4'h0;
      bus_rsp <= '0;
    end
    else
    begin
      // Idle lines carry a changing pattern, never the last answer
      junk_q <= ~junk_q;
      probe_done <= 1'b0;
      bus_done <= 1'b0;
      i2c_present <= junk_q[15:0];
      spi_present <= junk_q[3:0];
      bus_rsp <= junk_q;
      if ((probe_req && !probe_done) || (bus_valid && !bus_done))
        wait_q <= wait_q + 4'h1;
      if (probe_req && !probe_done && wait_q >= lat)
      begin
        probe_done <= 1'b1;
        i2c_present <= i2c_fit;
        spi_present <= spi_fit;
        wait_q <= 4'h0;
      end
      else if (bus_valid && !bus_done && wait_q >= lat)
      begin
        bus_done <= 1'b1;
        bus_rsp <= {val, nb};
        wait_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench of the sensor command interpreter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sensor_cmd_pkg::*;
  logic core_clk, rst, cmd_valid, cmd_ready, reply_valid, reply_ready;
  logic bulk_valid, bulk_ready, probe_req, probe_done, bus_valid, bus_done;
  logic bus_is_spi, collecting;
  logic [7:0] cmd_byte, bulk_data;
  logic [15:0] i2c_present, i2c_fit;
  logic [3:0] spi_present, spi_fit, lat, target_sel;
  reply_t reply;
  reply_t rq[$];
  bus_req_t bus_req, last_req;
  bus_rsp_t bus_rsp;
  int bq[$];
  int stamps[$];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 14;
  logic bv_q = 1'b0;
  string rforms[4] = '{"rreg b", "rreg 0B", "rreg 0x0B", "rreg 000b"};
  string bad[7] = '{"setdevice 5", "rreg 0X0B", "Rreg 1", "collect 50 112 49 5",
    "collect 50 128 49 1", "collect 50 112 53 2", "rreg 100"};

  sensor_cmd_interp i_sensor_cmd_interp (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply(reply),
    .reply_ready(reply_ready), .bulk_valid(bulk_valid), .bulk_data(bulk_data), .bulk_ready(bulk_ready),
    .probe_req(probe_req), .probe_done(probe_done), .i2c_present(i2c_present), .spi_present(spi_present),
    .bus_valid(bus_valid), .bus_req(bus_req), .bus_done(bus_done), .bus_rsp(bus_rsp),
    .bus_is_spi(bus_is_spi), .target_sel(target_sel), .collecting(collecting));
  sensor_bus_model i_sensor_bus_model (.core_clk(core_clk), .rst(rst), .i2c_fit(i2c_fit),
    .spi_fit(spi_fit), .lat(lat), .probe_req(probe_req), .probe_done(probe_done),
    .i2c_present(i2c_present), .spi_present(spi_present), .bus_valid(bus_valid),
    .bus_req(bus_req), .bus_done(bus_done), .bus_rsp(bus_rsp));

  // ********
  // Checking and reporting
  // ********
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t %s: %0h vs %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register value the sensor model returns, cut to its byte count
  function automatic logic [39:0] expv(input int t, input int a);
    int nb;
    longint v;
    nb = 2 + a % 3;
    v = t * 64'd16777216 + a * 64'd65536 + 64'h5ac3;
    return 40'(v & ((64'h1 << (8 * nb)) - 1));
  endfunction

  task automatic push_set(input int mask, input int list, input int cnt);
    int k, b, i, t;
    logic [39:0] v;
    for (k = 0; k < cnt; k++)
      for (b = 6; b >= 0; b--)
        if ((mask >> b) & 1)
        begin
          t = (list >> (4 * k)) & 15;
          v = expv(t, b);
          bq.push_back(0);
          bq.push_back(k + 1);
          bq.push_back(b);
          bq.push_back(2 + b % 3);
          for (i = 1 + b % 3; i >= 0; i--)
            bq.push_back(int'(v[8 * i +: 8]));
        end
  endtask

  // ********
  // Stimulus
  // ********
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    #1;
    bulk_ready = 1'($random(seed) & 1);
    reply_ready = 1'($random(seed) & 1);
    lat = 4'($random(seed) & 3);
  end

  always @(posedge core_clk)
  begin
    if (reply_valid && reply_ready)
      rq.push_back(reply);
    if (!rst && bulk_valid && bulk_ready)
    begin
      if (bq.size() == 0)
        check(0, 1, "extra bulk byte");
      else
        check(bulk_data, bq.pop_front(), "bulk byte");
    end
    if (bus_valid && !bv_q)
    begin
      last_req = bus_req;
      if (!bus_req.write && bus_req.addr == 8'h06 && bus_req.target == 4'h1)
        stamps.push_back(cyc);
    end
    bv_q = bus_valid;
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic do_reset(input logic [15:0] i2c, input logic [3:0] spi);
    int k;
    i2c_fit = i2c;
    spi_fit = spi;
    rst = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rq.delete();
    bq.delete();
    k = 0;
    do begin @(posedge core_clk); #1; k++; end while ((probe_req === 1'b1 || k < 3) && k < 200);
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input string s);
    int i, k;
    for (i = 0; i <= s.len(); i++)
    begin
      cmd_valid = 1'b1;
      cmd_byte = (i == s.len()) ? CH_LF : s[i];
      k = 0;
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && k < 2000)
      begin
        @(negedge core_clk);
        k++;
      end
      @(posedge core_clk);
      #1;
    end
    cmd_valid = 1'b0;
  endtask

  task automatic expect_reply(input cmd_kind_t kd, input logic hr, input logic [7:0] ad,
    input logic [39:0] v, input logic cl);
    reply_t r;
    int k;
    k = 0;
    do begin @(posedge core_clk); #1; k++; end while (rq.size() == 0 && k < 3000);
    if (rq.size() == 0)
    begin
      check(0, 1, "no reply");
      return;
    end
    r = rq.pop_front();
    check(r.kind, kd, "reply kind");
    check({r.has_reg, r.collecting}, {hr, cl}, "reply state");
    if (hr)
      check({r.addr, r.value}, {ad, v}, "register reply");
  endtask

  task automatic collect_run(input int iv, input int mask, input int list, input int cnt, input int sets);
    int s, k;
    stamps.delete();
    for (s = 0; s < sets; s++)
      push_set(mask, list, cnt);
    send($sformatf("collect %0d %0d %0d %0d", iv, mask, list, cnt));
    expect_reply(K_COLLECT, 1'b0, 8'h00, 40'h0, 1'b1);
    k = 0;
    while (bq.size() > 0 && k < 30 * iv * sets + 3000)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check(bq.size(), 0, "records missing");
    // First set waits on the reply handshake; only later sets are paced by the timer alone
    if (sets > 2)
      check(stamps[2] - stamps[1] inside {[iv * 20 - 2 : iv * 20 + 2]}, 1, "set period");
    send("stop");
    expect_reply(K_STOP, 1'b0, 8'h00, 40'h0, 1'b0);
    check(collecting, 0, "stopped");
    repeat (40) @(posedge core_clk);
    #1;
    $display("end collect %0d %0d %0d", mask, list, cnt);
  endtask

  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    do_reset(16'h0000, 4'ha);
    check({bus_is_spi, target_sel}, {1'b1, 4'h2}, "spi probe");
    send("setdevice 3");
    expect_reply(K_SETDEV, 1'b0, 8'h00, 40'h0, 1'b0);
    check(target_sel, 3, "target");
    foreach (rforms[i])
    begin
      send(rforms[i]);
      expect_reply(K_RREG, 1'b1, 8'h0b, expv(3, 11), 1'b0);
      check({last_req.write, last_req.is_spi, last_req.target, last_req.addr}, 14'h130b, "read req");
    end
    send("wreg 0x01 0xFB69");
    expect_reply(K_WREG, 1'b0, 8'h00, 40'h0, 1'b0);
    check(last_req, {14'h3301, 32'hfb69}, "write req");
    foreach (bad[i])
    begin
      send(bad[i]);
      repeat (30) @(posedge core_clk);
      #1;
      check({rq.size(), target_sel, collecting}, {32'h0, 4'h3, 1'b0}, "refused line");
    end
    $display("end commands");
    collect_run(50, 112, 49, 2, 3);
    collect_run(50, 127, 17185, 4, 1);
    do_reset(16'h0000, 4'h0);
    check({bus_is_spi, target_sel}, {1'b1, 4'h1}, "fallback");
    do_reset(16'h0a04, 4'h0);
    check({bus_is_spi, target_sel}, {1'b0, 4'h2}, "i2c probe");
    send("setdevice 10");
    expect_reply(K_SETDEV, 1'b0, 8'h00, 40'h0, 1'b0);
    check(target_sel, 10, "i2c target");
    send("rreg 0x3");
    expect_reply(K_RREG, 1'b1, 8'h03, expv(10, 3), 1'b0);
    check({last_req.is_spi, last_req.target, last_req.addr}, 13'h0a03, "i2c req");
    collect_run(50, 64, 162, 2, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
